// ===== verilog/asf_formatter.v
// Purpose: I2S and DSP serial audio output formatter with Avalon-MM
//          register access, time slots, swap, inversion and tri-state
// Assumes: CLK at 25 MHz, far above the bit clock rate
// Notes:   bit and word clocks are sampled pins in slave operation
//
// Overview of operation
// - I2S first channel MSB, second rise after fall
// - I2S other channel MSB, second rise after rise
// - DSP frame on word rise, left then right
// - DSP data valid on falling edge unless inverted
// - slots: first after offset1, second after offset2
// - swapped slots send right first, then left
// - tri-state release on every non-data bit slot
// - bit clock inversion swaps launch and sample edges
// - time slots use independent offsets, else offset2 is zero
// - generated clocks run only powered, unless kept
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "asf_regs.vh"

module asf_formatter #(
	parameter [7:0] DIV_HALF = `ASF_BCLK_HALF_DIV,
	parameter       CW       = `ASF_CNT_W
) (
	// clock and reset
	input  wire        CLK,
	input  wire        RSTN,
	// avalon-mm slave
	input  wire [4:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	input  wire [3:0]  AVS_BYTEENABLE,
	output reg  [31:0] AVS_READDATA,
	output reg         AVS_WAITREQUEST,
	// bit clock pin
	input  wire        BCLK_I,
	output wire        BCLK_O,
	output reg         BCLK_OEN,
	// word clock pin
	input  wire        WCLK_I,
	output wire        WCLK_O,
	output reg         WCLK_OEN,
	// serial data pin
	output reg         SDOUT_O,
	output reg         SDOUT_OEN
);

	// ****************************************************************
	// helper functions
	// ****************************************************************
	// byte-lane merge of a write into a word
	function [31:0] be_merge;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0]  be;
		integer k;
		begin
			be_merge = old_v;
			for (k = 0; k < 4; k = k + 1) begin
				if (be[k]) begin
					be_merge[k*8 +: 8] = new_v[k*8 +: 8];
				end
			end
		end
	endfunction

	// bit counter inside a slot of given start and length
	function in_slot;
		input [CW-1:0] cnt;
		input [CW-1:0] st;
		input [CW-1:0] len;
		begin
			in_slot = (cnt >= st) && (cnt < st + len);
		end
	endfunction

	// msb-first bit pick of a word at slot position
	function pick_bit;
		input [31:0]   w;
		input [CW-1:0] cnt;
		input [CW-1:0] st;
		input [CW-1:0] len;
		reg   [CW-1:0] idx;
		begin
			idx      = len - {{(CW-1){1'b0}}, 1'b1} - (cnt - st);
			pick_bit = w[idx[4:0]];
		end
	endfunction

	// ****************************************************************
	// registers
	// ****************************************************************
	reg [7:0]    ctrl_r;
	reg [5:0]    wlen_r;
	reg [7:0]    off1_r;
	reg [7:0]    off2_r;
	reg [31:0]   left_r;
	reg [31:0]   right_r;
	reg [8:0]    half_r;
	reg          frame_flag_r;
	reg [31:0]   hold_l_r;
	reg [31:0]   hold_r_r;
	reg [CW-1:0] cnt_r;
	reg          bclk_prev_r;
	reg          wclk_last_r;

	wire         m_dsp    = ctrl_r[`ASF_CTRL_DSP];
	wire         m_tslot  = ctrl_r[`ASF_CTRL_TSLOT];
	wire         m_swap   = ctrl_r[`ASF_CTRL_SWAP];
	wire         m_binv   = ctrl_r[`ASF_CTRL_BINV];
	wire         m_tri    = ctrl_r[`ASF_CTRL_TRI];
	wire         m_pwr    = ctrl_r[`ASF_CTRL_PWR];
	wire         m_keep   = ctrl_r[`ASF_CTRL_KEEP];
	wire         m_master = ctrl_r[`ASF_CTRL_MASTER];

	wire         clk_run  = m_master & (m_pwr | m_keep);
	wire         launch_rise = m_dsp ^ m_binv;
	wire         i2s_half = !m_dsp && !m_tslot;

	// ****************************************************************
	// link clocks: pin sampling or local generation
	// ****************************************************************
	wire         bclk_pin;
	wire         wclk_pin;
	wire         gen_bclk;
	wire         gen_wclk;

	asf_pin_sync u_sync_bclk (
		.clk  (CLK),
		.rstn (RSTN),
		.d    (BCLK_I),
		.q    (bclk_pin)
	);

	asf_pin_sync u_sync_wclk (
		.clk  (CLK),
		.rstn (RSTN),
		.d    (WCLK_I),
		.q    (wclk_pin)
	);

	asf_clk_gen #(
		.DIV_HALF (DIV_HALF)
	) u_gen (
		.clk         (CLK),
		.rstn        (RSTN),
		.run         (clk_run),
		.launch_rise (launch_rise),
		.bclks_half  (half_r),
		.bclk        (gen_bclk),
		.wclk        (gen_wclk)
	);

	assign BCLK_O = gen_bclk;
	assign WCLK_O = gen_wclk;

	wire bclk_now = m_master ? gen_bclk : bclk_pin;
	wire wclk_now = m_master ? gen_wclk : wclk_pin;

	// ****************************************************************
	// frame timing
	// ****************************************************************
	// data changes on the launch edge, receiver samples the other
	wire launch    = (bclk_now != bclk_prev_r) &&
	                 (bclk_now == launch_rise);
	wire wclk_edge = launch && (wclk_now != wclk_last_r);
	// half-frame i2s starts at both edges, else at one edge only
	wire start     = i2s_half ? wclk_edge :
	                 (wclk_edge && (wclk_now == m_dsp));
	wire [CW-1:0] cnt_max = {CW{1'b1}};
	wire [CW-1:0] cnt_now = start ? {CW{1'b0}} :
	                        ((cnt_r == cnt_max) ? cnt_r :
	                         cnt_r + {{(CW-1){1'b0}}, 1'b1});

	// slot positions; i2s adds one bclk of standard delay
	wire [CW-1:0] dly  = m_dsp ? {CW{1'b0}} :
	                     {{(CW-1){1'b0}}, 1'b1};
	wire [CW-1:0] wl   = {{(CW-6){1'b0}}, wlen_r};
	wire [CW-1:0] o1   = {{(CW-8){1'b0}}, off1_r};
	wire [CW-1:0] o2   = m_tslot ? {{(CW-8){1'b0}}, off2_r} :
	                     {CW{1'b0}};
	wire [CW-1:0] st1  = o1 + dly;
	wire [CW-1:0] st2  = st1 + wl + o2;

	wire hit1 = in_slot(cnt_now, st1, wl);
	wire hit2 = !i2s_half && in_slot(cnt_now, st2, wl);

	// low word clock half carries left in plain i2s
	wire ch1_right = i2s_half ? (wclk_now ^ m_swap) : m_swap;
	// fresh samples at frame start, so the first bit is never stale
	wire latch = start && (!i2s_half || !(wclk_now ^ m_swap) || m_swap);
	wire [31:0] cur_l = latch ? left_r : hold_l_r;
	wire [31:0] cur_r = latch ? right_r : hold_r_r;
	wire [31:0] word1 = ch1_right ? cur_r : cur_l;
	wire [31:0] word2 = ch1_right ? cur_l : cur_r;

	wire bit_now = hit1 ? pick_bit(word1, cnt_now, st1, wl) :
	               hit2 ? pick_bit(word2, cnt_now, st2, wl) :
	               1'b0;

	// edge tracking, bit counter and sample capture
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			bclk_prev_r <= 1'b0;
			wclk_last_r <= 1'b0;
			cnt_r       <= {CW{1'b0}};
			hold_l_r    <= `ASF_WORD_RST;
			hold_r_r    <= `ASF_WORD_RST;
		end else begin
			bclk_prev_r <= bclk_now;
			if (launch) begin
				wclk_last_r <= wclk_now;
				cnt_r       <= cnt_now;
			end
			if (latch) begin
				hold_l_r <= left_r;
				hold_r_r <= right_r;
			end
		end
	end

	// serial data and release of unused slots
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			SDOUT_O   <= 1'b0;
			SDOUT_OEN <= 1'b1;
		end else if (!m_pwr) begin
			SDOUT_O   <= 1'b0;
			SDOUT_OEN <= m_tri;
		end else if (launch) begin
			SDOUT_O   <= bit_now;
			SDOUT_OEN <= m_tri && !(hit1 || hit2);
		end
	end

	// clock pin drivers enabled in master operation
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			BCLK_OEN <= 1'b1;
			WCLK_OEN <= 1'b1;
		end else begin
			BCLK_OEN <= !m_master;
			WCLK_OEN <= !m_master;
		end
	end

	// ****************************************************************
	// avalon-mm slave
	// ****************************************************************
	wire take_wr = AVS_WRITE && !AVS_WAITREQUEST;
	wire [31:0] wd = AVS_WRITEDATA;
	wire [3:0]  be = AVS_BYTEENABLE;
	reg  [31:0] rd_val;
	wire [31:0] half_m = be_merge({23'h00_0000, half_r}, wd, be);

	// read mux; unmapped offsets read zero
	always @* begin
		rd_val = 32'h0000_0000;
		case (AVS_ADDRESS)
		`ASF_OFS_CTRL:  rd_val[7:0] = ctrl_r;
		`ASF_OFS_WLEN:  rd_val[5:0] = wlen_r;
		`ASF_OFS_OFF1:  rd_val[7:0] = off1_r;
		`ASF_OFS_OFF2:  rd_val[7:0] = off2_r;
		`ASF_OFS_LEFT:  rd_val = left_r;
		`ASF_OFS_RIGHT: rd_val = right_r;
		`ASF_OFS_HALF:  rd_val[8:0] = half_r;
		`ASF_OFS_STAT: begin
			rd_val[`ASF_STAT_FRAME] = frame_flag_r;
			rd_val[`ASF_STAT_RUN]   = clk_run;
			rd_val[`ASF_STAT_CNT_LO +: CW] = cnt_r;
		end
		default:        rd_val = 32'h0000_0000;
		endcase
	end

	// one wait cycle, then answer; request taken at waitrequest low
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= 32'h0000_0000;
		end else if ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST) begin
			AVS_WAITREQUEST <= 1'b0;
			AVS_READDATA    <= rd_val;
		end else begin
			AVS_WAITREQUEST <= 1'b1;
		end
	end

	// register writes with byte enables
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_r  <= `ASF_CTRL_RST;
			wlen_r  <= `ASF_WLEN_RST;
			off1_r  <= `ASF_OFF_RST;
			off2_r  <= `ASF_OFF_RST;
			left_r  <= `ASF_WORD_RST;
			right_r <= `ASF_WORD_RST;
			half_r  <= `ASF_HALF_RST;
		end else if (take_wr) begin
			case (AVS_ADDRESS)
			`ASF_OFS_CTRL:  if (be[0]) ctrl_r <= wd[7:0];
			`ASF_OFS_WLEN:  if (be[0]) wlen_r <= wd[5:0];
			`ASF_OFS_OFF1:  if (be[0]) off1_r <= wd[7:0];
			`ASF_OFS_OFF2:  if (be[0]) off2_r <= wd[7:0];
			`ASF_OFS_LEFT:  left_r  <= be_merge(left_r, wd, be);
			`ASF_OFS_RIGHT: right_r <= be_merge(right_r, wd, be);
			`ASF_OFS_HALF:  half_r <= half_m[8:0];
			default: ;
			endcase
		end
	end

	// sticky frame flag; capture wins over a write-one clear
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			frame_flag_r <= 1'b0;
		end else if (start) begin
			frame_flag_r <= 1'b1;
		end else if (take_wr && (AVS_ADDRESS == `ASF_OFS_STAT) &&
		             be[0] && wd[`ASF_STAT_FRAME]) begin
			frame_flag_r <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ===== verilog/asf_regs.vh
// Purpose: register map, field positions and reset values of the
//          serial audio formatter
// Assumes: 32-bit Avalon-MM data, byte addresses, aligned words
// Notes:   definitions only
`ifndef ASF_REGS_VH
`define ASF_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ASF_ADDR_W        5
`define ASF_OFS_CTRL      5'h00
`define ASF_OFS_WLEN      5'h04
`define ASF_OFS_OFF1      5'h08
`define ASF_OFS_OFF2      5'h0C
`define ASF_OFS_LEFT      5'h10
`define ASF_OFS_RIGHT     5'h14
`define ASF_OFS_HALF      5'h18
`define ASF_OFS_STAT      5'h1C

// ****************************************************************
// control fields
// ****************************************************************
`define ASF_CTRL_DSP      0
`define ASF_CTRL_TSLOT    1
`define ASF_CTRL_SWAP     2
`define ASF_CTRL_BINV     3
`define ASF_CTRL_TRI      4
`define ASF_CTRL_PWR      5
`define ASF_CTRL_KEEP     6
`define ASF_CTRL_MASTER   7

// ****************************************************************
// status fields
// ****************************************************************
`define ASF_STAT_FRAME    0
`define ASF_STAT_RUN      1
`define ASF_STAT_CNT_LO   8

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define ASF_CTRL_RST      8'h00
`define ASF_WLEN_RST      6'h10
`define ASF_OFF_RST       8'h00
`define ASF_HALF_RST      9'h020
`define ASF_WORD_RST      32'h0000_0000
`define ASF_BCLK_HALF_DIV 8'h04
`define ASF_CNT_W         10

`endif

// ===== verilog/asf_pin_sync.v
// Purpose: three-stage synchroniser with agreement filter for a pin
// Assumes: d is asynchronous to clk
// Notes:   q follows only when the second and third stages agree
`timescale 1ns/1ps
`default_nettype none

module asf_pin_sync (
	// clock and reset
	input  wire clk,
	input  wire rstn,
	// pin in, filtered level out
	input  wire d,
	output reg  q
);

	reg s1_r;
	reg s2_r;
	reg s3_r;

	// ****************************************************************
	// synchroniser chain
	// ****************************************************************
	// first stage feeds only the second stage
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			q    <= 1'b0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r) begin
				q <= s3_r;
			end
		end
	end

endmodule

`default_nettype wire

// ===== verilog/asf_clk_gen.v
// Purpose: bit clock and word clock generator for master operation
// Assumes: one system clock; bit clock half period is DIV_HALF cycles
// Notes:   clocks freeze in place while run is low
`timescale 1ns/1ps
`default_nettype none
`include "asf_regs.vh"

module asf_clk_gen #(
	parameter [7:0] DIV_HALF = `ASF_BCLK_HALF_DIV
) (
	// clock and reset
	input  wire       clk,
	input  wire       rstn,
	// control
	input  wire       run,
	input  wire       launch_rise,
	input  wire [8:0] bclks_half,
	// generated clocks
	output reg        bclk,
	output reg        wclk
);

	reg [7:0] div_r;
	reg [8:0] cnt_r;

	// ****************************************************************
	// divider and half-frame counter
	// ****************************************************************
	// word clock toggles on the launch edge of the bit clock
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_r <= 8'h00;
			cnt_r <= 9'h000;
			bclk  <= 1'b0;
			wclk  <= 1'b0;
		end else if (!run) begin
			div_r <= 8'h00;
		end else if (div_r == DIV_HALF - 8'h01) begin
			div_r <= 8'h00;
			bclk  <= ~bclk;
			if ((~bclk) == launch_rise) begin
				if (cnt_r >= bclks_half - 9'h001) begin
					cnt_r <= 9'h000;
					wclk  <= ~wclk;
				end else begin
					cnt_r <= cnt_r + 9'h001;
				end
			end
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

endmodule

`default_nettype wire

// ===== test/asf_host_model.sv
// Purpose: host audio processor model, slave clocks and data capture
// Assumes: 40 bit clocks a frame, bit clock period 320 ns
// Notes:   clocks stand still between frames
`timescale 1ns/1ps
`default_nettype none

module asf_host_model (
	// frame request and format
	input  wire logic        go,
	input  wire logic        dsp,
	input  wire logic        inv,
	// serial data from the device
	input  wire logic        sd,
	input  wire logic        sd_oen,
	// clocks out, captured bits
	output logic             bclk,
	output logic             wclk,
	output logic             done,
	output logic [39:0]      bits,
	output logic [39:0]      hiz
);
	logic sv;

	// idle levels at start
	initial begin
		bclk = 1'b1;
		wclk = 1'b1;
		done = 1'b0;
		bits = '0;
		hiz = '0;
	end

	// one frame; long launch-to-sample half lets the data settle
	always @(posedge go) begin
		done = 1'b0;
		sv = !dsp ^ inv;
		bclk = sv;
		#1010;
		// lead-in launch edge moves the word clock to its idle level
		bclk = !sv;
		wclk = !dsp;
		#220 bclk = sv;
		#100;
		for (int i = 0; i < 40; i++) begin
			bclk = !sv;
			if (i == 0) wclk = !wclk;
			if (dsp && i == 1) wclk = 1'b0;
			if (!dsp && i == 20) wclk = 1'b1;
			#220 bclk = sv;
			bits[i] = sd;
			hiz[i] = sd_oen;
			#100;
		end
		done = 1'b1;
	end
endmodule

`default_nettype wire

// ===== test/asf_formatter_sva.sv
// Purpose: port checker for the serial audio formatter
// Assumes: one clock domain, reset active low
// Notes:   bound from the bench top file
`timescale 1ns/1ps
`default_nettype none

module asf_formatter_sva #(
	parameter [7:0] DIV_HALF = 8'h04
) (
	// clock and reset
	input wire logic        CLK,
	input wire logic        RSTN,
	// register bus
	input wire logic [4:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	// pins
	input wire logic        BCLK_O,
	input wire logic        BCLK_OEN,
	input wire logic        WCLK_O,
	input wire logic        WCLK_OEN,
	input wire logic        SDOUT_O
);
	// ****
	// helpers
	// ****
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	logic [7:0] hc_r;
	logic       bo_r;
	sequence s_req;
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
	endsequence
	sequence s_ack;
		!AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
	endsequence

	// cycles since the generated bit clock last moved
	always @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			hc_r <= 8'h00;
			bo_r <= 1'b0;
		end else begin
			bo_r <= BCLK_O;
			if (BCLK_O != bo_r)
				hc_r <= 8'h00;
			else if (hc_r != 8'hFF)
				hc_r <= hc_r + 8'h01;
		end
	end

	// ****
	// assertions
	// ****
	a_req_served:
	assert property (s_req |=> s_ack) else $error("request not answered");
	a_wait_pulse:
	assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("wait low longer than one cycle");
	a_wait_cause:
	assert property ($fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
		else $error("answer without request");
	a_bad_addr:
	assert property (!AVS_WAITREQUEST && AVS_READ && AVS_ADDRESS[1:0] != 2'h0
		|-> AVS_READDATA == 32'h0000_0000) else $error("unaligned read data");
	a_sd_hold:
	assert property ($changed(SDOUT_O) && BCLK_OEN |=> $stable(SDOUT_O) [*5])
		else $error("serial data moved within a bit");
	a_bclk_half:
	assert property (BCLK_O != bo_r |-> hc_r >= DIV_HALF - 8'h01)
		else $error("bit clock half period short");
	a_wclk_launch:
	assert property ($changed(WCLK_O) |-> $changed(BCLK_O)
		|| $past(BCLK_O, 1) != $past(BCLK_O, 2))
		else $error("word clock off the bit clock edge");
	a_oen_pair:
	assert property (BCLK_OEN == WCLK_OEN) else $error("clock enables differ");
endmodule

`default_nettype wire

// ===== test/asf_formatter_tb.sv
// Purpose: self-checking bench for the serial audio formatter
// Assumes: slave clocks from the host model, 16-bit words
// Notes:   frames of 40 bit clocks, master clocks checked last
`timescale 1ns/1ps
`default_nettype none

module asf_formatter_tb;
	// ****
	// signals
	// ****
	logic        clk, rstn, rd, wr, go, dsp, inv, done;
	logic        wreq, bo, boen, wo, woen, sd, sdoen, hb, hw;
	logic [4:0]  adr;
	logic [31:0] wd, rdat;
	logic [39:0] bits, hiz;
	int          error_cnt, samples_checked;
	int          cyc = 0;
	localparam logic [31:0] lv = 32'h0000_A5C3;
	localparam logic [31:0] rv = 32'h0000_3C96;

	// device, pin levels resolved from the enables
	asf_formatter dut_u (.CLK(clk), .RSTN(rstn), .AVS_ADDRESS(adr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
		.AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
		.AVS_WAITREQUEST(wreq), .BCLK_I(boen ? hb : bo), .BCLK_O(bo),
		.BCLK_OEN(boen), .WCLK_I(woen ? hw : wo), .WCLK_O(wo),
		.WCLK_OEN(woen), .SDOUT_O(sd), .SDOUT_OEN(sdoen));
	asf_host_model host_u (.go(go), .dsp(dsp), .inv(inv), .sd(sdoen ? !sd : sd),
		.sd_oen(sdoen), .bclk(hb), .wclk(hw), .done(done), .bits(bits),
		.hiz(hiz));

	// clock and watchdog
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	// ****
	// shared tasks
	// ****
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one register access, held until wait is seen low
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] q);
		adr <= a;
		wd <= d;
		wr <= w;
		rd <= !w;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdat;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk);
	endtask

	// configure, run one frame, compare the data bit slots, and every slot's enable when tri-state is set
	task automatic frm(input logic [7:0] c, input logic [7:0] o1,
		input logic [7:0] o2);
		logic [31:0] q;
		logic [15:0] a, b;
		logic in1, in2;
		int f, s;
		bus(1'b1, 5'h00, {24'h00_0000, c}, q);
		bus(1'b1, 5'h08, {24'h00_0000, o1}, q);
		bus(1'b1, 5'h0C, {24'h00_0000, o2}, q);
		dsp <= c[0];
		inv <= c[3];
		go <= 1'b1;
		@(posedge clk);
		wait (done === 1'b1);
		@(posedge clk);
		go <= 1'b0;
		a = c[2] ? rv[15:0] : lv[15:0];
		b = c[2] ? lv[15:0] : rv[15:0];
		f = c[0] ? o1 : o1 + 1;
		s = (c[0] | c[1]) ? f + 16 + (c[1] ? o2 : 0) : 21 + o1;
		for (int k = 0; k < 40; k++) begin
			in1 = (k >= f) && (k < f + 16);
			in2 = (k >= s) && (k < s + 16);
			if (in1)
				chk(bits[k], a[15 - k + f]);
			else if (in2)
				chk(bits[k], b[15 - k + s]);
			if (c[4])
				chk(hiz[k], !(in1 || in2));
		end
	endtask

	// bit and word clock toggles over 64 cycles
	task automatic tgl(output int n, output int m);
		logic p, r;
		n = 0;
		m = 0;
		p = bo;
		r = wo;
		repeat (64) begin
			@(negedge clk);
			if (bo !== p) n++;
			if (wo !== r) m++;
			p = bo;
			r = wo;
		end
		@(posedge clk);
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_regs;
		logic [31:0] q;
		bus(1'b0, 5'h00, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		bus(1'b0, 5'h04, 32'h0000_0000, q);
		chk(q, 32'h0000_0010);
		bus(1'b1, 5'h0C, 32'h0000_0003, q);
		bus(1'b0, 5'h0C, 32'h0000_0000, q);
		chk(q, 32'h0000_0003);
		bus(1'b0, 5'h01, 32'h0000_0000, q);
		chk(q, 32'h0000_0000);
		bus(1'b1, 5'h10, lv, q);
		bus(1'b1, 5'h14, rv, q);
	endtask

	task automatic t_i2s;
		frm(8'h20, 8'h00, 8'h00);
	endtask

	task automatic t_i2s_inv;
		frm(8'h28, 8'h02, 8'h00);
	endtask

	task automatic t_dsp;
		frm(8'h21, 8'h00, 8'h00);
	endtask

	task automatic t_slot;
		frm(8'h33, 8'h00, 8'h03);
	endtask

	task automatic t_swap;
		frm(8'h3F, 8'h00, 8'h03);
	endtask

	task automatic t_master;
		logic [31:0] q;
		int n, m;
		bus(1'b1, 5'h18, 32'h0000_0004, q);
		bus(1'b1, 5'h00, 32'h0000_0080, q);
		tgl(n, m);
		chk(n, 0);
		chk(m, 0);
		chk(boen, 1'b0);
		chk(woen, 1'b0);
		bus(1'b1, 5'h00, 32'h0000_00C0, q);
		repeat (16) @(posedge clk);
		tgl(n, m);
		chk(n, 16);
		chk(m, 2);
		bus(1'b1, 5'h00, 32'h0000_00A0, q);
		repeat (16) @(posedge clk);
		tgl(n, m);
		chk(n, 16);
		chk(m, 2);
	endtask

	// main sequence
	initial begin
		rstn = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		go = 1'b0;
		dsp = 1'b0;
		inv = 1'b0;
		adr = 5'h00;
		wd = 32'h0000_0000;
		error_cnt = 0;
		samples_checked = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_i2s();
		t_i2s_inv();
		t_dsp();
		t_slot();
		t_swap();
		t_master();
		conclude();
	end
endmodule

bind asf_formatter asf_formatter_sva #(.DIV_HALF(DIV_HALF)) sva_u (
	.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.BCLK_O(BCLK_O), .BCLK_OEN(BCLK_OEN), .WCLK_O(WCLK_O),
	.WCLK_OEN(WCLK_OEN), .SDOUT_O(SDOUT_O));

`default_nettype wire
